// ===== rtl/fll_regs.svh
`ifndef FLL_REGS_SVH
`define FLL_REGS_SVH
`define FLL_IDX_ENABLE 10'h171
`define FLL_IDX_INTEGER 10'h172
`define FLL_IDX_NUMER 10'h173
`define FLL_IDX_DENOM 10'h174
`define FLL_IDX_RATIO 10'h175
`define FLL_IDX_REFSEL 10'h176
`define FLL_IDX_FORCED 10'h177
`define FLL_IDX_READBACK 10'h178
`define FLL_IDX_GAIN 10'h179
`define FLL_BIT_ENA 0
`define FLL_BIT_FREERUN 1
`define FLL_BIT_APPLY 15
`define FLL_BIT_VALID 15
`define FLL_RST_ENA 1'b0
`define FLL_RST_FREERUN 1'b1
`define FLL_RST_MULT 10'h008
`define FLL_RST_NUMER 16'h0018
`define FLL_RST_DENOM 16'h007D
`define FLL_RST_RATIO 4'h0
`define FLL_RST_PREDIV 2'h0
`define FLL_RST_SRC 4'h0
`define FLL_RST_FORCED 12'h281
`define FLL_RST_GAIN 4'h0
`define FLL_GAIN_SAT 9'h100
`endif

// ===== rtl/fll_pkg.sv
package fll_pkg;
  typedef logic [15:0] word_t;
  typedef logic [9:0] mult_t;
  typedef logic [11:0] integ_t;
endpackage : fll_pkg

// ===== rtl/fll_control_register_bank.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "fll_regs.svh"
module fll_control_register_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Loop status pins
  input wire logic reference_present_i,
  input wire logic loop_integrator_valid_i,
  input wire logic [11:0] loop_integrator_i,
  // Loop controls
  output logic loop_enable_o,
  output logic free_running_o,
  output logic [9:0] integer_multiplier_o,
  output logic [15:0] fraction_numerator_o,
  output logic [15:0] fraction_denominator_o,
  output logic [4:0] oscillator_divide_o,
  output logic [3:0] reference_divide_o,
  output logic [3:0] reference_source_o,
  output logic reference_source_ok_o,
  output logic [8:0] loop_gain_o,
  output logic settings_apply_o,
  output logic forced_integrator_apply_o,
  output logic [11:0] forced_integrator_value_o
);

  function automatic fll_pkg::word_t merge(
    input fll_pkg::word_t old_v,
    input fll_pkg::word_t new_v,
    input logic [1:0] lanes
  );
    merge = {lanes[1] ? new_v[15:8] : old_v[15:8],
             lanes[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge

  function automatic logic [8:0] gain_of(input logic [3:0] code);
    gain_of = code[3] ? `FLL_GAIN_SAT : 9'(9'h001 << code[2:0]);
  endfunction : gain_of

  function automatic logic src_ok(input logic [3:0] code);
    src_ok = (code == 4'h0) || (code == 4'h1) || (code == 4'h3) ||
             (code == 4'h8) || (code == 4'h9) || (code == 4'hA) ||
             (code == 4'hC) || (code == 4'hD) || (code == 4'hE);
  endfunction : src_ok

  logic ena_r;
  logic freerun_r;
  fll_pkg::mult_t mult_r;
  fll_pkg::word_t numer_r;
  fll_pkg::word_t denom_r;
  logic [3:0] ratio_r;
  logic [1:0] prediv_r;
  logic [3:0] src_r;
  fll_pkg::integ_t forced_r;
  logic [3:0] gain_r;
  fll_pkg::mult_t act_mult_r;
  fll_pkg::word_t act_numer_r;
  logic apply_r;
  logic frc_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic ref_meta_r;
  logic ref_sync_r;
  logic vld_meta_r;
  logic vld_sync_r;
  logic vld_late_r;
  fll_pkg::integ_t integ_meta_r;
  fll_pkg::integ_t integ_sync_r;
  fll_pkg::integ_t integ_r;

  // Bus decode
  wire req = cyc_i & stb_i & ~ack_r;
  wire wr = req & we_i;
  wire [9:0] idx = adr_i[11:2];
  wire hit_ena = idx == `FLL_IDX_ENABLE;
  wire hit_int = idx == `FLL_IDX_INTEGER;
  wire hit_num = idx == `FLL_IDX_NUMER;
  wire hit_den = idx == `FLL_IDX_DENOM;
  wire hit_rat = idx == `FLL_IDX_RATIO;
  wire hit_ref = idx == `FLL_IDX_REFSEL;
  wire hit_frc = idx == `FLL_IDX_FORCED;
  wire hit_rb = idx == `FLL_IDX_READBACK;
  wire hit_gain = idx == `FLL_IDX_GAIN;
  wire [15:0] wd = dat_i[15:0];
  wire [1:0] ln = sel_i[1:0];

  wire fll_pkg::word_t ena_w = merge(
    {14'h0000, freerun_r, ena_r}, wd, ln);
  wire fll_pkg::word_t int_w = merge({6'h00, mult_r}, wd, ln);
  wire fll_pkg::word_t num_w = merge(numer_r, wd, ln);
  wire fll_pkg::word_t den_w = merge(denom_r, wd, ln);
  wire fll_pkg::word_t rat_w = merge({4'h0, ratio_r, 8'h00}, wd, ln);
  wire fll_pkg::word_t ref_w = merge(
    {8'h00, prediv_r, 2'h0, src_r}, wd, ln);
  wire fll_pkg::word_t frc_w = merge({4'h0, forced_r}, wd, ln);
  wire fll_pkg::word_t gain_w = merge({10'h000, gain_r, 2'h0}, wd, ln);

  wire fll_pkg::mult_t mult_nxt = (wr & hit_int) ? int_w[9:0] : mult_r;
  wire fll_pkg::word_t numer_nxt = (wr & hit_num) ? num_w : numer_r;
  wire fll_pkg::integ_t forced_nxt =
    (wr & hit_frc) ? frc_w[11:0] : forced_r;

  wire apply_req = wr & hit_int & ln[1] & wd[`FLL_BIT_APPLY];
  wire frc_req = wr & hit_frc & ln[1] & wd[`FLL_BIT_APPLY];
  // Start-up takes staged values, as enable is set last
  // Decoded from the write itself so the pulse matches a direct apply
  wire ena_wr = wr & hit_ena;
  wire ena_rise = ena_wr & ena_w[`FLL_BIT_ENA] & ~ena_r;
  // Start-up mode is the one written together with the enable
  wire free_nxt = ena_wr ? ena_w[`FLL_BIT_FREERUN] : freerun_r;
  wire apply_go = (apply_req & ena_r) | ena_rise;
  // forced load only when free running
  wire frc_go = (frc_req | ena_rise) & free_nxt;

  // meaningful only in free-run with loop valid
  wire rb_valid = vld_sync_r & freerun_r & ena_r;

  wire [15:0] rd_word =
    hit_ena ? {14'h0000, freerun_r, ena_r} :
    hit_int ? {6'h00, mult_r} :
    hit_num ? numer_r :
    hit_den ? denom_r :
    hit_rat ? {4'h0, ratio_r, 8'h00} :
    hit_ref ? {8'h00, prediv_r, 2'h0, src_r} :
    hit_frc ? {4'h0, forced_r} :
    hit_rb ? {rb_valid, 3'h0, integ_r} :
    hit_gain ? {10'h000, gain_r, 2'h0} : 16'h0000;

  // Bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= req;
      rdata_r <= (req & ~we_i) ? {16'h0000, rd_word} : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ena_r <= `FLL_RST_ENA;
      freerun_r <= `FLL_RST_FREERUN;
      mult_r <= `FLL_RST_MULT;
      numer_r <= `FLL_RST_NUMER;
      denom_r <= `FLL_RST_DENOM;
      ratio_r <= `FLL_RST_RATIO;
      prediv_r <= `FLL_RST_PREDIV;
      src_r <= `FLL_RST_SRC;
      forced_r <= `FLL_RST_FORCED;
      gain_r <= `FLL_RST_GAIN;
    end else begin
      if (wr & hit_ena) begin
        ena_r <= ena_w[`FLL_BIT_ENA];
        freerun_r <= ena_w[`FLL_BIT_FREERUN];
      end
      mult_r <= mult_nxt;
      numer_r <= numer_nxt;
      forced_r <= forced_nxt;
      if (wr & hit_den) denom_r <= den_w;
      if (wr & hit_rat) ratio_r <= rat_w[11:8];
      if (wr & hit_ref) begin
        prediv_r <= ref_w[7:6];
        src_r <= ref_w[3:0];
      end
      if (wr & hit_gain) gain_r <= gain_w[5:2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_mult_r <= `FLL_RST_MULT;
      act_numer_r <= `FLL_RST_NUMER;
      apply_r <= 1'b0;
      frc_r <= 1'b0;
    end else begin
      apply_r <= apply_go;
      frc_r <= frc_go;
      if (apply_go) begin
        act_mult_r <= mult_nxt;
        act_numer_r <= numer_nxt;
      end
    end
  end

  // Pins from the analogue loop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_meta_r <= 1'b0;
      ref_sync_r <= 1'b0;
      vld_meta_r <= 1'b0;
      vld_sync_r <= 1'b0;
      vld_late_r <= 1'b0;
      integ_meta_r <= 12'h000;
      integ_sync_r <= 12'h000;
    end else begin
      ref_meta_r <= reference_present_i;
      ref_sync_r <= ref_meta_r;
      vld_meta_r <= loop_integrator_valid_i;
      vld_sync_r <= vld_meta_r;
      vld_late_r <= vld_sync_r;
      integ_meta_r <= loop_integrator_i;
      integ_sync_r <= integ_meta_r;
    end
  end

  // integrator capture
  // Word taken a cycle after valid is seen, so all its bits have settled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      integ_r <= 12'h000;
    end else if (frc_go) begin
      integ_r <= forced_nxt;
    end else if (vld_sync_r & vld_late_r) begin
      integ_r <= integ_sync_r;
    end
  end

  assign dat_o = rdata_r;
  assign ack_o = ack_r;
  assign loop_enable_o = ena_r;
  assign free_running_o = ena_r & (freerun_r | ~ref_sync_r);
  assign integer_multiplier_o = act_mult_r;
  assign fraction_numerator_o = act_numer_r;
  assign fraction_denominator_o = denom_r;
  assign oscillator_divide_o = {1'b0, ratio_r} + 5'h01;
  assign reference_divide_o = 4'(4'h1 << prediv_r);
  assign reference_source_o = src_r;
  assign reference_source_ok_o = src_ok(src_r);
  assign loop_gain_o = gain_of(gain_r);
  assign settings_apply_o = apply_r;
  assign forced_integrator_apply_o = frc_r;
  assign forced_integrator_value_o = forced_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  a_apply_loads: assert property (
    apply_req && ena_r |=> settings_apply_o &&
    integer_multiplier_o == $past(mult_nxt))
    else $error("apply did not load multiplier");
  a_apply_disabled: assert property (
    apply_req && !ena_r |=> !settings_apply_o &&
    $stable(integer_multiplier_o))
    else $error("apply acted while disabled");
  a_hold_staged: assert property (
    !apply_go |=> $stable(integer_multiplier_o) &&
    $stable(fraction_numerator_o))
    else $error("active settings changed without apply");
  a_pulse_once: assert property (
    settings_apply_o && !$past(apply_go, 2) |-> ##1 !settings_apply_o)
    else $error("apply pulse too long");
  a_strobe_zero: assert property (
    ack_o && !we_i && (hit_int || hit_frc) |-> !dat_o[15])
    else $error("strobe bit read as one");
  a_forced_gate: assert property (
    frc_req && !freerun_r |=> !forced_integrator_apply_o)
    else $error("forced load outside free run");
  a_forced_copy: assert property (
    forced_integrator_apply_o |-> integ_r == forced_r)
    else $error("forced value not in readback");
  a_valid_read: assert property (
    req && !we_i && hit_rb |=> dat_o[15] == $past(rb_valid))
    else $error("valid flag misread");
  a_ref_lost: assert property (
    ena_r && $fell(ref_sync_r) |-> free_running_o)
    else $error("no free run on lost reference");
  a_relock: assert property (
    ena_r && !freerun_r && ref_sync_r |-> !free_running_o)
    else $error("no relock with reference back");
  a_gain_sat: assert property (
    gain_r[3] |-> loop_gain_o == 9'h100)
    else $error("gain not saturated");
  a_ratio_div: assert property (
    ratio_r == 4'hF |-> oscillator_divide_o == 5'h10)
    else $error("ratio decode wrong");

  c_apply: cover property (apply_req && ena_r ##1 settings_apply_o);
  c_forced: cover property (frc_req && freerun_r);
  c_ref_drop: cover property (ena_r && !freerun_r && $fell(ref_sync_r));
  c_valid: cover property (rb_valid && ack_o && hit_rb);

endmodule : fll_control_register_bank

// ===== dv/testbench.sv
`timescale 1ns/1ps
`include "fll_regs.svh"
module testbench;
  localparam int MASK [9] = '{3, 'h3FF, 'hFFFF, 'hFFFF, 'hF00, 'hCF,
    'hFFF, 0, 'h3C};
  localparam int RST [9] = '{2, 8, 'h18, 'h7D, 0, 0, 'h281, 0, 0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic reference_present_i = 1'b1;
  logic loop_integrator_valid_i = 1'b0;
  logic [11:0] loop_integrator_i = 12'h000;
  logic loop_enable_o;
  logic free_running_o;
  logic [9:0] integer_multiplier_o;
  logic [15:0] fraction_numerator_o;
  logic [15:0] fraction_denominator_o;
  logic [4:0] oscillator_divide_o;
  logic [3:0] reference_divide_o;
  logic [3:0] reference_source_o;
  logic reference_source_ok_o;
  logic [8:0] loop_gain_o;
  logic settings_apply_o;
  logic forced_integrator_apply_o;
  logic [11:0] forced_integrator_value_o;
  int mdl [9];
  int act_mult;
  int act_num;
  int integ_m;
  int num_errors = 0;
  int total_checks = 0;
  logic apply_seen;
  logic forced_seen;

  fll_control_register_bank fll_control_register_bank_i (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .reference_present_i(reference_present_i),
    .loop_integrator_valid_i(loop_integrator_valid_i),
    .loop_integrator_i(loop_integrator_i), .loop_enable_o(loop_enable_o),
    .free_running_o(free_running_o),
    .integer_multiplier_o(integer_multiplier_o),
    .fraction_numerator_o(fraction_numerator_o),
    .fraction_denominator_o(fraction_denominator_o),
    .oscillator_divide_o(oscillator_divide_o),
    .reference_divide_o(reference_divide_o),
    .reference_source_o(reference_source_o),
    .reference_source_ok_o(reference_source_ok_o),
    .loop_gain_o(loop_gain_o), .settings_apply_o(settings_apply_o),
    .forced_integrator_apply_o(forced_integrator_apply_o),
    .forced_integrator_value_o(forced_integrator_value_o));

  always #25 clk_i = ~clk_i;

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; held until ack is sampled, then released
  task automatic bus(input logic [9:0] idx, input logic wr,
                     input logic [15:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h3;
    dat_i <= {16'h0000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    apply_seen = settings_apply_o;
    forced_seen = forced_integrator_apply_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      num_errors++;
      $display("MISMATCH t=%0t no bus answer", $time);
      complete_run();
    end
  endtask : bus

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    logic [31:0] rd;
    logic was_en;
    logic ea;
    logic ef;
    int k;
    k = int'(idx) - 'h171;
    was_en = mdl[0][0];
    ea = 1'b0;
    ef = 1'b0;
    bus(idx, 1'b1, d, rd);
    if (k >= 0 && k < 9 && k != 7) mdl[k] = d & MASK[k];
    if ((k == 1 && d[15] && mdl[0][0]) || (k == 0 && !was_en && d[0])) begin
      ea = 1'b1;
      act_mult = mdl[1];
      act_num = mdl[2];
    end
    if ((k == 6 && d[15] && mdl[0][1]) || (k == 0 && ea && d[1])) begin
      ef = 1'b1;
      integ_m = mdl[6];
    end
    chk(32'(apply_seen), 32'(ea));
    chk(32'(forced_seen), 32'(ef));
  endtask : wr

  task automatic rd_chk(input logic [9:0] idx);
    logic [31:0] rd;
    logic [31:0] ex;
    int k;
    k = int'(idx) - 'h171;
    ex = 32'h0000_0000;
    bus(idx, 1'b0, 16'h0000, rd);
    if (k >= 0 && k < 9) ex = 32'(mdl[k] & MASK[k]);
    if (k == 7) ex = {16'h0000, loop_integrator_valid_i & mdl[0][1] &
      mdl[0][0], 3'b000, 12'(integ_m)};
    chk(rd, ex);
  endtask : rd_chk

  task automatic pins;
    int g;
    int r;
    logic ok;
    g = (mdl[8] >> 2) & 15;
    r = (mdl[5] >> 6) & 3;
    ok = (mdl[5] & 15) inside {0, 1, 3, 8, 9, 10, 12, 13, 14};
    chk(32'(loop_enable_o), 32'(mdl[0] & 1));
    chk(32'(free_running_o), 32'(mdl[0][0] & (mdl[0][1] |
      !reference_present_i)));
    chk(32'(integer_multiplier_o), 32'(act_mult));
    chk(32'(fraction_numerator_o), 32'(act_num));
    chk(32'(fraction_denominator_o), 32'(mdl[3]));
    chk(32'(oscillator_divide_o), 32'(((mdl[4] >> 8) & 15) + 1));
    chk(32'(reference_divide_o), 32'(1 << r));
    chk(32'(reference_source_o), 32'(mdl[5] & 15));
    chk(32'(reference_source_ok_o), 32'(ok));
    chk(32'(loop_gain_o), 32'(g < 8 ? (1 << g) : 256));
    chk(32'(forced_integrator_value_o), 32'(mdl[6]));
  endtask : pins

  initial begin
    int i;
    int s;
    logic [15:0] v;
    s = $urandom(32'h1bd9290b);
    mdl = RST;
    act_mult = 8;
    act_num = 'h18;
    integ_m = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    pins();
    for (i = 0; i < 10; i++) rd_chk(10'h171 + 10'(i));
    $display("Test reset values done");
    wr(`FLL_IDX_INTEGER, 16'h8010);
    pins();
    rd_chk(`FLL_IDX_INTEGER);
    $display("Test apply while disabled done");
    for (i = 0; i < 16; i++) begin
      v = 16'($urandom);
      wr(`FLL_IDX_NUMER, v);
      wr(`FLL_IDX_DENOM, ~v);
      wr(`FLL_IDX_RATIO, {v[15:12], 4'(i), v[7:0]});
      wr(`FLL_IDX_REFSEL, {v[15:8], 2'(i), v[5:4], 4'(i)});
      wr(`FLL_IDX_GAIN, {v[15:6], 4'(i), v[1:0]});
      pins();
      rd_chk(`FLL_IDX_RATIO);
      rd_chk(`FLL_IDX_REFSEL);
      rd_chk(`FLL_IDX_GAIN);
    end
    $display("Test field codes done");
    wr(`FLL_IDX_ENABLE, 16'h0001);
    pins();
    wr(`FLL_IDX_INTEGER, 16'h0123);
    wr(`FLL_IDX_NUMER, 16'($urandom));
    pins();
    wr(`FLL_IDX_INTEGER, 16'h8155);
    wr(`FLL_IDX_INTEGER, 16'h83FF);
    pins();
    wr(`FLL_IDX_FORCED, 16'h8ABC);
    rd_chk(`FLL_IDX_READBACK);
    $display("Test apply while enabled done");
    reference_present_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    pins();
    reference_present_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    pins();
    $display("Test reference loss done");
    wr(`FLL_IDX_ENABLE, 16'h0002);
    wr(`FLL_IDX_ENABLE, 16'h0003);
    pins();
    wr(`FLL_IDX_FORCED, 16'h8000 | 16'($urandom & 'hFFF));
    rd_chk(`FLL_IDX_READBACK);
    v = 16'($urandom);
    loop_integrator_i <= v[11:0];
    loop_integrator_valid_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    integ_m = v[11:0];
    rd_chk(`FLL_IDX_READBACK);
    wr(`FLL_IDX_READBACK, 16'hFFFF);
    rd_chk(`FLL_IDX_READBACK);
    wr(10'h000, 16'hFFFF);
    rd_chk(10'h000);
    rd_chk(10'h3FF);
    pins();
    $display("Test free running and readback done");
    complete_run();
  end
endmodule : testbench
